// file: hdl/rcd_pkg.sv
package rcd_pkg;

    // Register addresses on the CPU and debug access ports.
    localparam int unsigned        ADDR_W            = 16;
    localparam logic [ADDR_W-1:0] STATUS_ADDR       = 16'h0040;
    localparam logic [ADDR_W-1:0] FORCE_ADDR        = 16'h0041;

    // Field positions of the reset cause status register.
    localparam int unsigned        BIT_POWER_ON      = 7;
    localparam int unsigned        BIT_EXT_PIN       = 6;
    localparam int unsigned        BIT_WATCHDOG      = 5;
    localparam int unsigned        BIT_ILLEGAL_OP    = 4;
    localparam int unsigned        BIT_ILLEGAL_ADDR  = 3;
    localparam int unsigned        BIT_LOW_VOLTAGE   = 1;

    // Field position of the debug force reset bit.
    localparam int unsigned        BIT_FORCE         = 0;

    // Status values loaded for each class of reset.
    localparam logic [7:0]         STATUS_POR_VALUE  = 8'h82;
    localparam logic [7:0]         STATUS_LV_VALUE   = 8'h02;
    localparam logic [7:0]         STATUS_CLEARED    = 8'h00;
    localparam logic [7:0]         STATUS_IMPL_MASK  = 8'hfa;
    localparam logic [7:0]         READ_ZERO         = 8'h00;

    // Length of the system reset pulse driven after a reset entry.
    localparam int unsigned        CLK_PERIOD_PS     = 25000;
    localparam int unsigned        RESET_HOLD_NS     = 1000;
    localparam int unsigned        RESET_HOLD_CYCLES =
        (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned        HOLD_CNT_W        = 16;

    // Top-level sequencing states.
    typedef enum logic [0:0] {
        RCD_ST_RUN  = 1'b0,
        RCD_ST_HOLD = 1'b1
    } rcd_state_type;

endpackage

// file: hdl/rcd_hold_timer.sv
`timescale 1ns/1ps
module rcd_hold_timer
    import rcd_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYCLES
) (
    // Clock and reset.
    input  wire logic CLK,
    input  wire logic SRST,
    // Control.
    input  wire logic START,
    output logic      ACTIVE
);

    localparam logic [HOLD_CNT_W-1:0] LOAD_VALUE = HOLD_CNT_W'(HOLD_CYCLES - 1);
    localparam logic [HOLD_CNT_W-1:0] CNT_ZERO   = '0;
    localparam logic [HOLD_CNT_W-1:0] CNT_ONE    = HOLD_CNT_W'(1);

    logic [HOLD_CNT_W-1:0] cnt_q;
    logic                  active_q;

    // A start reloads the count even while active, so a held pin or supply source stretches the pulse.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_q    <= CNT_ZERO;
            active_q <= 1'b0;
        end else if (START) begin
            cnt_q    <= LOAD_VALUE;
            active_q <= 1'b1;
        end else if (active_q) begin
            if (cnt_q == CNT_ZERO) begin
                active_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end

    assign ACTIVE = active_q;

endmodule

// file: hdl/rcd_reset_cause.sv
// Notes on behaviour
// - An 8-bit read-only status register reports which source caused the last reset.
// - A debug-forced reset clears every flag in the status register.
// - Any write to the status address restarts the watchdog; flags stay unchanged.
// - Power-on reset sets bit 7 and bit 1, all other flags clear.
// - Enabled low-voltage trip resets the device and sets only bit 1.
// - Other resets set bits 6..3 per active source; bits 7 and 1 clear.
// - Low level on the external reset pin sets bit 6.
// - Watchdog timeout sets bit 5; no such reset while watchdog is disabled.
// - Illegal or unimplemented instruction execution sets bit 4.
// - Stop instruction counts as illegal opcode while stop mode is disabled.
// - Background-entry instruction counts as illegal while background mode is disabled.
// - Access to an unimplemented memory address sets bit 3.
// - The force reset register holds one write-only bit and always reads zero.
// - User program writes to the force reset register are ignored.
// - Debug write of 1 to force bit 0 forces a full system reset.
`timescale 1ns/1ps
module rcd_reset_cause
    import rcd_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYCLES
) (
    // Clock and synchronous power-on reset.
    input  wire logic              CLK,
    input  wire logic              SRST,
    // CPU register port.
    input  wire logic [ADDR_W-1:0] CPU_ADDR,
    input  wire logic              CPU_WR,
    input  wire logic              CPU_RD,
    output logic      [7:0]        CPU_RDATA,
    // Serial background debug write port.
    input  wire logic [ADDR_W-1:0] BDC_ADDR,
    input  wire logic              BDC_WR,
    input  wire logic [7:0]        BDC_WDATA,
    // Reset sources.
    input  wire logic              EXT_RESET_N,
    input  wire logic              LOW_VOLTAGE_TRIP,
    input  wire logic              LOW_VOLTAGE_RESET_ENABLE,
    input  wire logic              WDOG_TIMEOUT,
    input  wire logic              WATCHDOG_ENABLE,
    input  wire logic              ILLEGAL_OPCODE,
    input  wire logic              STOP_EXEC,
    input  wire logic              STOP_MODE_ENABLE,
    input  wire logic              BACKGROUND_ENTRY_EXEC,
    input  wire logic              BACKGROUND_MODE_ENABLE,
    input  wire logic              ILLEGAL_ADDRESS,
    // System side.
    output logic                   SYS_RESET,
    output logic                   WDOG_RESTART
);

    rcd_state_type state_q;
    rcd_state_type state_d;
    logic [7:0]    status_q;
    logic [7:0]    status_d;
    logic [7:0]    rdata_q;
    logic          wdog_restart_q;
    logic          hold_active;
    logic          in_reset;
    logic          force_hit;
    logic          lv_hit;
    logic          pin_hit;
    logic          wd_hit;
    logic          opcode_hit;
    logic          address_hit;
    logic          any_src;
    logic          enter;
    logic          timer_start;
    logic          status_wr;
    logic          cpu_force_wr;

    // Address compare used by both access ports.
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ref_addr);
        addr_is = (a == ref_addr);
    endfunction

    assign in_reset = (state_q == RCD_ST_HOLD);

    // Only the debug port can reach the force bit; the CPU write is decoded but dropped.
    assign force_hit    = BDC_WR && addr_is(BDC_ADDR, FORCE_ADDR)
                          && BDC_WDATA[BIT_FORCE];
    assign cpu_force_wr = CPU_WR && addr_is(CPU_ADDR, FORCE_ADDR);

    // Qualified reset sources.
    assign lv_hit   = LOW_VOLTAGE_TRIP && LOW_VOLTAGE_RESET_ENABLE;
    assign pin_hit  = !EXT_RESET_N;
    assign wd_hit   = WDOG_TIMEOUT && WATCHDOG_ENABLE;
    assign opcode_hit  = ILLEGAL_OPCODE
                         || (STOP_EXEC && !STOP_MODE_ENABLE)
                         || (BACKGROUND_ENTRY_EXEC && !BACKGROUND_MODE_ENABLE);
    assign address_hit = ILLEGAL_ADDRESS;

    assign any_src = force_hit || lv_hit || pin_hit || wd_hit || opcode_hit || address_hit;
    assign enter   = !in_reset && any_src;

    // A pin or supply still asserted during the hold keeps the system in reset.
    assign timer_start = enter || (in_reset && (pin_hit || lv_hit));

    // Writes to the status address from either port restart the watchdog.
    assign status_wr = (CPU_WR && addr_is(CPU_ADDR, STATUS_ADDR))
                       || (BDC_WR && addr_is(BDC_ADDR, STATUS_ADDR));

    // Reset pulse stretcher; its flop drives the system reset directly.
    rcd_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .CLK    (CLK),
        .SRST   (SRST),
        .START  (timer_start),
        .ACTIVE (hold_active)
    );

    // Leave the hold state once the pulse has ended and nothing restarts it.
    always_comb begin
        state_d = state_q;
        case (state_q)
            RCD_ST_RUN: begin
                if (enter) begin
                    state_d = RCD_ST_HOLD;
                end
            end
            RCD_ST_HOLD: begin
                if (!hold_active && !timer_start) begin
                    state_d = RCD_ST_RUN;
                end
            end
            default: begin
                state_d = RCD_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q <= RCD_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Cause capture at reset entry. Force beats every other source, low voltage comes next,
    // and the remaining sources are recorded together since several may be active at once.
    always_comb begin
        status_d = status_q;
        if (enter) begin
            if (force_hit) begin
                status_d = STATUS_CLEARED;
            end else if (lv_hit) begin
                status_d = STATUS_LV_VALUE;
            end else begin
                status_d                   = STATUS_CLEARED;
                status_d[BIT_EXT_PIN]      = pin_hit;
                status_d[BIT_WATCHDOG]     = wd_hit;
                status_d[BIT_ILLEGAL_OP]   = opcode_hit;
                status_d[BIT_ILLEGAL_ADDR] = address_hit;
            end
        end
    end

    // The status register has no write path at all; the data of a write is discarded.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            status_q <= STATUS_POR_VALUE;
        end else begin
            status_q <= status_d & STATUS_IMPL_MASK;
        end
    end

    // Watchdog restart pulse, one cycle after the write.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            wdog_restart_q <= 1'b0;
        end else begin
            wdog_restart_q <= status_wr;
        end
    end

    // Read data stands for one cycle after the read strobe; everything else reads zero.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_q <= READ_ZERO;
        end else if (CPU_RD && addr_is(CPU_ADDR, STATUS_ADDR)) begin
            rdata_q <= status_q;
        end else begin
            rdata_q <= READ_ZERO;
        end
    end

    assign CPU_RDATA    = rdata_q;
    assign WDOG_RESTART = wdog_restart_q;
    assign SYS_RESET    = hold_active;

    // Length of the reset pulse so far; a pulse cut short would leave the system half reset.
    logic [HOLD_CNT_W-1:0] pulse_len_q;

    always_ff @(posedge CLK) begin
        if (SRST || !hold_active) begin
            pulse_len_q <= '0;
        end else if (pulse_len_q != '1) begin
            pulse_len_q <= pulse_len_q + HOLD_CNT_W'(1);
        end
    end

    // Power-on value is present on the first cycle after reset release.
    property p_por_value;
        @(posedge CLK) $fell(SRST) |-> (status_q == STATUS_POR_VALUE);
    endproperty
    a_por_value: assert property (p_por_value)
        else $error("status not at power-on value after reset");

    // A debug force clears all flags and raises the reset at once; its length is checked below.
    property p_force_clear;
        @(posedge CLK) disable iff (SRST)
        (force_hit && !in_reset) |=> (status_q == STATUS_CLEARED) && SYS_RESET;
    endproperty
    a_force_clear: assert property (p_force_clear)
        else $error("forced reset did not clear flags or assert reset");

    // A CPU write to the force address alone never starts a reset.
    property p_cpu_force_ignored;
        @(posedge CLK) disable iff (SRST)
        (cpu_force_wr && !any_src && !in_reset) |=> !SYS_RESET && $stable(status_q);
    endproperty
    a_cpu_force_ignored: assert property (p_cpu_force_ignored)
        else $error("user write to force register had an effect");

    // A status write restarts the watchdog and leaves the flags as they were.
    property p_status_write;
        @(posedge CLK) disable iff (SRST)
        (status_wr && !enter) |=> WDOG_RESTART && (status_q == $past(status_q));
    endproperty
    a_status_write: assert property (p_status_write)
        else $error("status write misbehaved");

    // A low-voltage entry without force records only the low-voltage flag.
    property p_lv_entry;
        @(posedge CLK) disable iff (SRST)
        (enter && lv_hit && !force_hit) |=> (status_q == STATUS_LV_VALUE);
    endproperty
    a_lv_entry: assert property (p_lv_entry)
        else $error("low-voltage reset recorded wrong flags");

    // Other entries clear the power-on and low-voltage flags and copy the pin source.
    property p_other_entry;
        @(posedge CLK) disable iff (SRST)
        (enter && !lv_hit && !force_hit) |=>
            !status_q[BIT_POWER_ON] && !status_q[BIT_LOW_VOLTAGE]
            && (status_q[BIT_EXT_PIN] == $past(pin_hit));
    endproperty
    a_other_entry: assert property (p_other_entry)
        else $error("ordinary reset recorded wrong flags");

    // A timeout with the watchdog disabled and no other source starts no reset.
    property p_wd_blocked;
        @(posedge CLK) disable iff (SRST)
        (WDOG_TIMEOUT && !WATCHDOG_ENABLE && !any_src && !in_reset) |=> !SYS_RESET;
    endproperty
    a_wd_blocked: assert property (p_wd_blocked)
        else $error("disabled watchdog caused a reset");

    // Stop with stop mode disabled becomes an illegal-opcode reset.
    property p_stop_illegal;
        @(posedge CLK) disable iff (SRST)
        (STOP_EXEC && !STOP_MODE_ENABLE && !in_reset && !force_hit && !lv_hit) |=>
            status_q[BIT_ILLEGAL_OP] && SYS_RESET;
    endproperty
    a_stop_illegal: assert property (p_stop_illegal)
        else $error("disabled stop did not cause illegal-opcode reset");

    // Reads of the force register always return zero.
    property p_force_reads_zero;
        @(posedge CLK) disable iff (SRST)
        (CPU_RD && addr_is(CPU_ADDR, FORCE_ADDR)) |=> (CPU_RDATA == READ_ZERO);
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero)
        else $error("force register read was not zero");

    // Reserved status bits never show a one on the read port.
    property p_reserved_zero;
        @(posedge CLK) disable iff (SRST)
        (CPU_RDATA & ~STATUS_IMPL_MASK) == READ_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read as one");

    // Every reset pulse stands for at least the full hold time, however it was started.
    property p_pulse_length;
        @(posedge CLK) disable iff (SRST)
        ($fell(SYS_RESET) && !$past(SRST)) |-> (pulse_len_q >= HOLD_CNT_W'(HOLD_CYCLES));
    endproperty
    a_pulse_length: assert property (p_pulse_length)
        else $error("system reset pulse shorter than the hold time");

    // Other entries copy the watchdog source into its flag.
    property p_wd_flag;
        @(posedge CLK) disable iff (SRST)
        (enter && !lv_hit && !force_hit) |=> (status_q[BIT_WATCHDOG] == $past(wd_hit));
    endproperty
    a_wd_flag: assert property (p_wd_flag)
        else $error("watchdog flag does not match its source");

    // Other entries copy the illegal-opcode source into its flag.
    property p_opcode_flag;
        @(posedge CLK) disable iff (SRST)
        (enter && !lv_hit && !force_hit) |=> (status_q[BIT_ILLEGAL_OP] == $past(opcode_hit));
    endproperty
    a_opcode_flag: assert property (p_opcode_flag)
        else $error("illegal-opcode flag does not match its source");

    // Other entries copy the illegal-address source into its flag.
    property p_address_flag;
        @(posedge CLK) disable iff (SRST)
        (enter && !lv_hit && !force_hit) |=> (status_q[BIT_ILLEGAL_ADDR] == $past(address_hit));
    endproperty
    a_address_flag: assert property (p_address_flag)
        else $error("illegal-address flag does not match its source");

    // Background entry with background mode disabled becomes an illegal-opcode reset.
    property p_entry_illegal;
        @(posedge CLK) disable iff (SRST)
        (BACKGROUND_ENTRY_EXEC && !BACKGROUND_MODE_ENABLE && !in_reset && !force_hit && !lv_hit)
            |=> status_q[BIT_ILLEGAL_OP] && SYS_RESET;
    endproperty
    a_entry_illegal: assert property (p_entry_illegal)
        else $error("disabled background entry did not cause illegal-opcode reset");

    // A status read returns the flags as they stood when the strobe was taken.
    property p_status_read;
        @(posedge CLK) disable iff (SRST)
        (CPU_RD && addr_is(CPU_ADDR, STATUS_ADDR)) |=> (CPU_RDATA == $past(status_q));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong flags");

    // The watchdog restart never rises unless a status write came in the cycle before.
    property p_wdog_idle;
        @(posedge CLK) disable iff (SRST)
        !status_wr |=> !WDOG_RESTART;
    endproperty
    a_wdog_idle: assert property (p_wdog_idle)
        else $error("watchdog restart without a status write");

    // Sources that arrive while the reset pulse stands are not recorded.
    property p_hold_keeps_flags;
        @(posedge CLK) disable iff (SRST)
        in_reset |=> (status_q == $past(status_q));
    endproperty
    a_hold_keeps_flags: assert property (p_hold_keeps_flags)
        else $error("flags changed while reset was held");

endmodule

// file: verification/rcd_debug_host.sv
`timescale 1ns/1ps
module rcd_debug_host
    import rcd_pkg::*;
(
    // Clock.
    input  wire logic              clk,
    // Debug write port towards the device.
    output logic      [ADDR_W-1:0] bdc_addr,
    output logic                   bdc_wr,
    output logic      [7:0]        bdc_wdata,
    // Mode select pin, pulled high while nobody drives it.
    output logic                   mode_pin
);
    // Idle lines: strobe low, address away from the block, pin at its pull-up level.
    initial begin
        bdc_addr  = 16'hffff;
        bdc_wr    = 1'b0;
        bdc_wdata = 8'h00;
        mode_pin  = 1'b1;
    end

    // One byte write command. The lines are inverted on release so that a device
    // which samples late sees garbage instead of a convenient stale value.
    task automatic write_byte(input logic [ADDR_W-1:0] addr, input logic [7:0] data,
                              input logic user_mode);
        @(posedge clk);
        #1;
        bdc_addr  = addr;
        bdc_wdata = data;
        bdc_wr    = 1'b1;
        @(posedge clk);
        #1;
        bdc_wr    = 1'b0;
        bdc_addr  = ~addr;
        bdc_wdata = ~data;
        mode_pin  = user_mode;
    endtask
endmodule

// file: verification/rcd_reset_cause_bench.sv
`timescale 1ns/1ps
module rcd_reset_cause_bench;
    import rcd_pkg::*;
    localparam int unsigned HOLD = 4;
    logic              clk, srst, cpu_wr, cpu_rd, bdc_wr, sys_reset, wdog_restart, mode_pin;
    logic [ADDR_W-1:0] cpu_addr, bdc_addr;
    logic [7:0]        cpu_rdata, bdc_wdata;
    logic              ext_n, lvt, lve, wdt, wde, bad_op, stp, sme, bentry, bme, bad_ad, rd_pend;
    logic [7:0]        expq[$];
    logic [31:0]       seed, r;
    int                n_mismatch, compares, n;

    rcd_reset_cause #(.HOLD_CYCLES(HOLD)) dut (
        .CLK(clk), .SRST(srst), .CPU_ADDR(cpu_addr), .CPU_WR(cpu_wr), .CPU_RD(cpu_rd),
        .CPU_RDATA(cpu_rdata), .BDC_ADDR(bdc_addr), .BDC_WR(bdc_wr), .BDC_WDATA(bdc_wdata),
        .EXT_RESET_N(ext_n), .LOW_VOLTAGE_TRIP(lvt), .LOW_VOLTAGE_RESET_ENABLE(lve),
        .WDOG_TIMEOUT(wdt), .WATCHDOG_ENABLE(wde), .ILLEGAL_OPCODE(bad_op), .STOP_EXEC(stp),
        .STOP_MODE_ENABLE(sme), .BACKGROUND_ENTRY_EXEC(bentry), .BACKGROUND_MODE_ENABLE(bme),
        .ILLEGAL_ADDRESS(bad_ad), .SYS_RESET(sys_reset), .WDOG_RESTART(wdog_restart));
    rcd_debug_host host (.clk(clk), .bdc_addr(bdc_addr), .bdc_wr(bdc_wr),
        .bdc_wdata(bdc_wdata), .mode_pin(mode_pin));

    // Clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Xorshift source; a fixed start keeps every run identical.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reads only note the expected byte; the monitor below judges the answer.
    task automatic cpu_read(input logic [ADDR_W-1:0] addr, input logic [7:0] exp);
        @(posedge clk);
        #1;
        cpu_rd   = 1'b1;
        cpu_addr = addr;
        expq.push_back(exp);
        @(posedge clk);
        #1;
        cpu_rd   = 1'b0;
    endtask

    task automatic cpu_write(input logic [ADDR_W-1:0] addr, input logic restart);
        @(posedge clk);
        #1;
        cpu_wr   = 1'b1;
        cpu_addr = addr;
        @(posedge clk);
        #1;
        cpu_wr   = 1'b0;
        check({7'h00, wdog_restart}, {7'h00, restart});
        check({7'h00, sys_reset}, 8'h00);
    endtask

    // One reset source case: pulse the sources for a cycle, let any hold run out,
    // then read back the cause. Pulse bits are pin, trip, watchdog, opcode, stop,
    // background entry and address; enables are trip, watchdog, stop, background.
    task automatic run(input logic [6:0] p, input logic [3:0] en, input logic [7:0] st,
                       input logic r);
        @(posedge clk);
        #1;
        {lve, wde, sme, bme} = en;
        {lvt, wdt, bad_op, stp, bentry, bad_ad} = p[5:0];
        ext_n = ~p[6];
        @(posedge clk);
        #1;
        {lvt, wdt, bad_op, stp, bentry, bad_ad} = 6'h00;
        ext_n = 1'b1;
        check({7'h00, sys_reset}, {7'h00, r});
        repeat (HOLD + 3) @(posedge clk);
        #1;
        check({7'h00, sys_reset}, 8'h00);
        cpu_read(STATUS_ADDR, st);
    endtask

    // Result monitor: a read answer shows one cycle after its strobe was taken.
    always @(posedge clk) rd_pend <= cpu_rd & ~srst;
    always @(negedge clk) begin
        if (rd_pend) begin
            check(cpu_rdata, expq.pop_front());
        end
    end

    // Watchdog against a hung run; the whole sequence needs well under 1000 cycles.
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial begin
        {srst, ext_n, lve, wde, sme, bme} = 6'h3f;
        {cpu_wr, cpu_rd, lvt, wdt, bad_op, stp, bentry, bad_ad} = 8'h00;
        cpu_addr = 16'h0000;
        seed = 32'd52;
        n_mismatch = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        cpu_read(STATUS_ADDR, STATUS_POR_VALUE);
        cpu_read(FORCE_ADDR, READ_ZERO);
        cpu_write(STATUS_ADDR, 1'b1);
        cpu_write(FORCE_ADDR, 1'b0);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            cpu_read({8'h80, r[7:0]}, READ_ZERO);
            host.write_byte(STATUS_ADDR, r[15:8], 1'b1);
            check({7'h00, wdog_restart}, 8'h01);
        end
        cpu_read(STATUS_ADDR, STATUS_POR_VALUE);
        run(7'h40, 4'h7, 8'h40, 1'b1);
        run(7'h10, 4'h7, 8'h20, 1'b1);
        run(7'h10, 4'h3, 8'h20, 1'b0);
        run(7'h08, 4'h7, 8'h10, 1'b1);
        run(7'h01, 4'h7, 8'h08, 1'b1);
        run(7'h04, 4'h5, 8'h10, 1'b1);
        run(7'h20, 4'hf, 8'h02, 1'b1);
        run(7'h04, 4'h7, 8'h02, 1'b0);
        run(7'h02, 4'h6, 8'h10, 1'b1);
        run(7'h02, 4'h7, 8'h10, 1'b0);
        run(7'h20, 4'h7, 8'h10, 1'b0);
        run(7'h51, 4'h7, 8'h68, 1'b1);
        run(7'h60, 4'hf, 8'h02, 1'b1);
        host.write_byte(FORCE_ADDR, 8'hfe, 1'b1);
        check({7'h00, sys_reset}, 8'h00);
        host.write_byte(FORCE_ADDR, 8'h01, 1'b0);
        check({7'h00, sys_reset}, 8'h01);
        n = 0;
        while (sys_reset === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n[7:0], 8'(HOLD));
        cpu_read(STATUS_ADDR, STATUS_CLEARED);
        cpu_read(FORCE_ADDR, READ_ZERO);
        @(posedge clk);
        #1;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        cpu_read(STATUS_ADDR, STATUS_POR_VALUE);
        repeat (3) @(posedge clk);
        results();
    end
endmodule
